// ---- rsf_pkg.sv ----
// types shared by the sensor fault report block
package rsf_pkg;

    // per-channel inputs from the analog front end, decoder and control register
    typedef struct packed {
        logic       cmdOn;        // pulse: control register commands the channel on
        logic       cmdOff;       // pulse: control register commands the channel off
        logic       currentLimit; // level: channel in current limit
        logic       overSupply;   // level: channel voltage above sensor supply voltage
        logic       overGndLeak;  // level: current above ground leak current limit
        logic       overBatLeak;  // level: current above battery leak current limit
        logic       overTemp;     // level: channel overtemperature
        logic       frameValid;   // pulse: valid sensor frame received
        logic       frameError;   // pulse: two start bits then decode or parity error
        logic       fifoEmpty;    // level: receive fifo holds no frame
        logic [9:0] payload;      // sensor payload, valid with frameValid
    } rsf_chan_in_t;

    // fault flags of one channel, most significant first as they sit in the word
    typedef struct packed {
        logic shortToGround;
        logic shortToBattery;
        logic overcurrentFlag;
        logic openSensorFlag;
        logic channelOvertemp;
        logic invalidFrame;
        logic emptyBufferFlag;
    } rsf_flags_t;

endpackage : rsf_pkg

// ---- rsf_regs.svh ----
// register offsets, field positions, reset values and timing counts of the sensor fault report block
`ifndef RSF_REGS_SVH
`define RSF_REGS_SVH

`define RSF_ADDR_W          8
`define RSF_ADDR_CH0        8'h50
`define RSF_ADDR_CH1        8'h51
`define RSF_WORD_W          20

`define RSF_BIT_FLT         15
`define RSF_BIT_ON          14
`define RSF_LOGICAL_CHANNEL_CODE_CH0        4'h0
`define RSF_LOGICAL_CHANNEL_CODE_CH1        4'h4
`define RSF_LOGICAL_CHANNEL_CODE_RESET      4'h0
`define RSF_EMPTY_BUFFER_FLAG_RESET    1'b1
`define RSF_PAYLOAD_RESET   10'h000

`define RSF_CRC_SEED        3'h7
`define RSF_CRC_POLY        3'h3

`define RSF_CLK_MHZ         10
`define RSF_STB_FILTER_US   100
`define RSF_STB_CYCLES      (`RSF_STB_FILTER_US * `RSF_CLK_MHZ)
`define RSF_QUAL_LIMIT      8

`endif

// ---- rsf_sensor_model.sv ----
// behavioural remote sensor and control source for one channel
module rsf_sensor_model
    import rsf_pkg::*;
(
    input  wire logic    clk_sys,
    input  wire logic    rst_n,
    input  rsf_chan_in_t req,
    output rsf_chan_in_t chanOut
);
    timeunit 1ns;
    timeprecision 1ns;
    rsf_chan_in_t outNext;
    // payload lines toggle when no frame is strobed, so a stale capture would show
    always_comb begin
        outNext         = req;
        outNext.payload = req.frameValid ? req.payload : ~chanOut.payload;
    end
    // reacts one clock after the bench asks; an error strobe is sent whenever the bench
    // asks for one, with no check of the start bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chanOut <= '0;
        end else begin
            chanOut <= outNext;
        end
    end
endmodule : rsf_sensor_model

// ---- rsf_top.sv ----
// fault and status reporting for the two remote sensor channels and their data registers
//
// Summary of operation
// - bits 19..17 of every word read from a mapped address hold a 3-bit crc computed over bits 16..0 of that word; unmapped reads return all zeros.
// - the fault summary bit is one while any of the five fault flags or the empty buffer flag is one.
// - with the fault summary set, bits 9..3 carry ground short, battery short, overcurrent, open, overtemp, invalid, empty.
// - power state sets on an on command and clears on soft reset, off command, ground short or overtemp.
// - each read loads the logical channel code, 0000 for remote unit 0 and 0100 for remote unit 1.
// - ground short is set in current limit, survives reads, clears on soft reset or off command.
// - battery short sets after the filter time above supply and clears on soft reset, read or off command.
// - overcurrent sets from an up/down qualified ground leak comparison and clears on soft reset, read or off.
// - open sensor sets from an up/down qualified battery leak comparison and clears on soft reset, read or off.
// - overtemp sets on an overtemperature condition, survives reads, clears on soft reset or off command.
// - invalid frame sets when a frame with two good start bits then shows a decode or parity error.
// - invalid frame clears on soft reset, read, off command, or when any of the five fault flags sets.
// - empty buffer resets to one and clears on a valid frame or when any of the five fault flags sets.
// - empty buffer sets on a read while the fifo is empty and none of the five fault flags is set.
// - with the fault summary clear, bits 9..0 carry the last sensor payload from the decoder.
`include "rsf_regs.svh"
module rsf_top
    import rsf_pkg::*;
#(
    parameter int unsigned STB_CYCLES = `RSF_STB_CYCLES,
    parameter int unsigned QUAL_LIMIT = `RSF_QUAL_LIMIT
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   softStateReset,
    input  wire logic                   warmStateReset,
    input  rsf_chan_in_t                chanIn [2],
    input  wire logic                   rdReq,
    input  wire logic [`RSF_ADDR_W-1:0] rdAddr,
    output logic [`RSF_WORD_W-1:0]      rdData,
    output logic                        rdValid,
    output logic                        rdUnmapped,
    output logic [1:0]                  chanOn
);
    localparam int unsigned SW = $clog2(STB_CYCLES + 1);
    localparam logic [SW-1:0] STB_TOP = SW'(STB_CYCLES);

    // serial crc over the 17 low bits, msb first
    function automatic logic [2:0] crc3(input logic [16:0] d);
        logic [2:0] c;
        logic       fb;
        c = `RSF_CRC_SEED;
        for (int i = 16; i >= 0; i--) begin
            fb = c[2] ^ d[i];
            c  = {c[1:0], 1'b0} ^ (fb ? `RSF_CRC_POLY : 3'h0);
        end
        return c;
    endfunction : crc3

    // both resets restore the same values, so they act as one synchronous clear
    logic                    stateClr;
    logic [1:0]              readCh;
    logic [16:0]             chanLow [2];
    logic [`RSF_WORD_W-1:0]  chanWord [2];
    logic [`RSF_WORD_W-1:0]  rdDataNext;
    logic                    hitAny;

    assign stateClr  = softStateReset | warmStateReset;
    assign readCh[0] = rdReq && (rdAddr == `RSF_ADDR_CH0);
    assign readCh[1] = rdReq && (rdAddr == `RSF_ADDR_CH1);
    assign hitAny    = |readCh;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            localparam logic [3:0] LOGICAL_CHANNEL_CODE = (ch == 0) ? `RSF_LOGICAL_CHANNEL_CODE_CH0 : `RSF_LOGICAL_CHANNEL_CODE_CH1;

            rsf_flags_t     flagsReg;
            rsf_flags_t     flagsNext;
            logic           onReg;
            logic           onNext;
            logic [3:0]     lcidReg;
            logic [3:0]     lcidNext;
            logic [9:0]     payloadReg;
            logic [9:0]     payloadNext;
            logic [SW-1:0]  stbCountReg;
            logic [SW-1:0]  stbCountNext;
            logic           clrCmd;
            logic           rd;
            logic           stgSet;
            logic           stbSet;
            logic           ocSet;
            logic           openSet;
            logic           tempSet;
            logic           faultRise;
            logic           anyFive;
            logic           faultSummary;

            assign clrCmd = stateClr | chanIn[ch].cmdOff;
            assign rd     = readCh[ch];

            // battery short filter: must stay above supply for the full time, any dip restarts it
            assign stbCountNext = (clrCmd || !chanIn[ch].overSupply) ? '0 :
                                  (stbCountReg != STB_TOP) ? stbCountReg + SW'(1) : stbCountReg;
            assign stbSet = chanIn[ch].overSupply && (stbCountReg == STB_TOP) && !clrCmd;

            // current comparators are noisy, so each is qualified by its own up/down counter
            rsf_updown_qual #(.LIMIT(QUAL_LIMIT)) u_oc_qual (
                .clk_sys   (clk_sys),
                .rst_n     (rst_n),
                .clear     (clrCmd),
                .above     (chanIn[ch].overGndLeak),
                .qualified (ocSet)
            );
            rsf_updown_qual #(.LIMIT(QUAL_LIMIT)) u_open_qual (
                .clk_sys   (clk_sys),
                .rst_n     (rst_n),
                .clear     (clrCmd),
                .above     (chanIn[ch].overBatLeak),
                .qualified (openSet)
            );

            assign stgSet  = chanIn[ch].currentLimit && !clrCmd;
            assign tempSet = chanIn[ch].overTemp && !clrCmd;

            // a fault flag going from zero to one
            assign faultRise = (stgSet && !flagsReg.shortToGround) || (stbSet && !flagsReg.shortToBattery) ||
                               (ocSet && !flagsReg.overcurrentFlag) || (openSet && !flagsReg.openSensorFlag) ||
                               (tempSet && !flagsReg.channelOvertemp);

            assign anyFive = flagsReg.shortToGround | flagsReg.shortToBattery | flagsReg.overcurrentFlag |
                             flagsReg.openSensorFlag | flagsReg.channelOvertemp;

            // off command and resets clear; a set arriving with a read clear wins over the read
            assign flagsNext.shortToGround   = stgSet | (flagsReg.shortToGround & ~clrCmd);
            assign flagsNext.shortToBattery  = stbSet | (flagsReg.shortToBattery & ~clrCmd & ~rd);
            assign flagsNext.overcurrentFlag = ocSet | (flagsReg.overcurrentFlag & ~clrCmd & ~rd);
            assign flagsNext.openSensorFlag  = openSet | (flagsReg.openSensorFlag & ~clrCmd & ~rd);
            assign flagsNext.channelOvertemp = tempSet | (flagsReg.channelOvertemp & ~clrCmd);
            // a new electrical fault explains the bad frame, so it cancels the invalid flag
            assign flagsNext.invalidFrame    = ~clrCmd & ~faultRise &
                                               (chanIn[ch].frameError | (flagsReg.invalidFrame & ~rd));
            // empty buffer returns to one on reset, like its power-on value
            assign flagsNext.emptyBufferFlag = stateClr ? `RSF_EMPTY_BUFFER_FLAG_RESET :
                                               (rd && chanIn[ch].fifoEmpty && !anyFive && !faultRise) ? 1'b1 :
                                               (chanIn[ch].frameValid || faultRise) ? 1'b0 :
                                               flagsReg.emptyBufferFlag;

            // power state: automatic turn-off on ground short or overtemp
            assign onNext = (stateClr || chanIn[ch].cmdOff || stgSet || tempSet) ? 1'b0 :
                            chanIn[ch].cmdOn ? 1'b1 : onReg;

            assign lcidNext    = rd ? LOGICAL_CHANNEL_CODE : lcidReg;
            assign payloadNext = stateClr ? `RSF_PAYLOAD_RESET :
                                 chanIn[ch].frameValid ? chanIn[ch].payload : payloadReg;

            assign faultSummary = anyFive | flagsReg.emptyBufferFlag;

            // word built from the present flags, so the read sees them before they clear
            assign chanLow[ch] = faultSummary ?
                                 {1'b0, 1'b1, onReg, lcidNext, flagsReg, 3'h0} :
                                 {1'b0, 1'b0, onReg, lcidNext, payloadReg};
            assign chanWord[ch] = {crc3(chanLow[ch]), chanLow[ch]};

            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    flagsReg    <= '{emptyBufferFlag: `RSF_EMPTY_BUFFER_FLAG_RESET, default: 1'b0};
                    onReg       <= 1'b0;
                    lcidReg     <= `RSF_LOGICAL_CHANNEL_CODE_RESET;
                    payloadReg  <= `RSF_PAYLOAD_RESET;
                    stbCountReg <= '0;
                end else begin
                    flagsReg    <= flagsNext;
                    onReg       <= onNext;
                    lcidReg     <= lcidNext;
                    payloadReg  <= payloadNext;
                    stbCountReg <= stbCountNext;
                end
            end

            assign chanOn[ch] = onReg;
        end
    endgenerate

    // read answer: captured word of the addressed channel, zero for any other address
    assign rdDataNext = readCh[0] ? chanWord[0] :
                        readCh[1] ? chanWord[1] : '0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdData     <= '0;
            rdValid    <= 1'b0;
            rdUnmapped <= 1'b0;
        end else begin
            rdData     <= rdReq ? rdDataNext : rdData;
            rdValid    <= rdReq;
            rdUnmapped <= rdReq & ~hitAny;
        end
    end
endmodule : rsf_top

// ---- rsf_top_checker.sv ----
// port assertions for the sensor fault report block
`include "rsf_regs.svh"
module rsf_top_checker
    import rsf_pkg::*;
#(
    parameter int unsigned STB_CYCLES = 1000,
    parameter int unsigned QUAL_LIMIT = 8
) (
    input wire logic                   clk_sys,
    input wire logic                   rst_n,
    input wire logic                   softStateReset,
    input wire logic                   warmStateReset,
    input rsf_chan_in_t                chanIn [2],
    input wire logic                   rdReq,
    input wire logic [`RSF_ADDR_W-1:0] rdAddr,
    input wire logic [`RSF_WORD_W-1:0] rdData,
    input wire logic                   rdValid,
    input wire logic                   rdUnmapped,
    input wire logic [1:0]             chanOn
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // decodes shared by several properties
    wire mapped = rdAddr == `RSF_ADDR_CH0 || rdAddr == `RSF_ADDR_CH1;
    wire anyRst = softStateReset || warmStateReset;
    wire quiet0 = !chanIn[0].currentLimit && !chanIn[0].overTemp && !chanIn[0].frameValid && !chanIn[0].frameError;
    // independent check code, msb first over the low seventeen bits
    function automatic logic [2:0] crcOf(input logic [16:0] w);
        logic [2:0] c;
        c = `RSF_CRC_SEED;
        for (int i = 16; i >= 0; i--) c = {c[1:0], 1'b0} ^ ((c[2] ^ w[i]) ? `RSF_CRC_POLY : 3'h0);
        return c;
    endfunction : crcOf
    sequence gndHit;
        chanIn[0].currentLimit && !chanIn[0].cmdOff && !anyRst;
    endsequence
    sequence rstHit;
        anyRst ##1 quiet0 && !rdReq && !chanIn[0].cmdOn;
    endsequence
    sequence readCh0;
        rdReq && rdAddr == `RSF_ADDR_CH0;
    endsequence
    read_answer_a: assert property (rdReq |=> rdValid) else $error("read not answered");
    chan_code_a: assert property (rdReq && mapped |=> !rdUnmapped && rdData[13:10] ==
        ($past(rdAddr) == `RSF_ADDR_CH1 ? `RSF_LOGICAL_CHANNEL_CODE_CH1 : `RSF_LOGICAL_CHANNEL_CODE_CH0)) else $error("bad channel code");
    unmapped_zero_a: assert property (rdReq && !mapped |=> rdUnmapped && rdData == 20'h0)
        else $error("unmapped read not refused");
    word_crc_a: assert property (rdValid && !rdUnmapped |-> rdData[19:17] == crcOf(rdData[16:0])
        && !rdData[16]) else $error("check code wrong");
    fault_sum_a: assert property (rdValid && rdData[15] |-> (|{rdData[9:5], rdData[3]})
        && rdData[2:0] == 3'h0) else $error("fault word malformed");
    off_cmd_a: assert property (chanIn[0].cmdOff |=> !chanOn[0]) else $error("off ignored");
    on_cmd_a: assert property (chanIn[0].cmdOn && !chanIn[0].cmdOff && !anyRst && quiet0 |=> chanOn[0])
        else $error("on ignored");
    gnd_short_a: assert property (gndHit ##1 readCh0 |=> rdData[15] && rdData[9] && !rdData[14])
        else $error("ground short not reported");
    reset_word_a: assert property (rstHit ##1 readCh0 |=> rdData[15:0] == 16'h8008)
        else $error("word after reset wrong");
endmodule : rsf_top_checker

// ---- rsf_top_tb.sv ----
// self-checking bench for the sensor fault report block
module rsf_top_tb;
    import rsf_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned STB = 4;
    localparam int unsigned QUAL = 2;
    logic         clk_sys = 1'b0;
    logic         rst_n = 1'b0;
    logic         softStateReset = 1'b0;
    logic         warmStateReset = 1'b0;
    logic         rdReq = 1'b0;
    logic [7:0]   rdAddr = 8'h00;
    logic [19:0]  rdData, word;
    logic         rdValid, rdUnmapped;
    logic [1:0]   chanOn;
    rsf_chan_in_t rq [2] = '{default: '0};
    rsf_chan_in_t chanIn [2];
    int           failures = 0;
    int           samples_checked = 0;
    always #50 clk_sys = ~clk_sys;
    for (genvar i = 0; i < 2; i++) begin : g_sens
        rsf_sensor_model rsf_sensor_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .req(rq[i]), .chanOut(chanIn[i]));
    end
    rsf_top #(.STB_CYCLES(STB), .QUAL_LIMIT(QUAL)) rsf_top_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .softStateReset(softStateReset), .warmStateReset(warmStateReset), .chanIn(chanIn), .rdReq(rdReq),
        .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid), .rdUnmapped(rdUnmapped), .chanOn(chanOn));
    task automatic end_of_test();
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic cmpW(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpW
    task automatic cmpB(input logic got, input logic exp);
        cmpW({16'h0, got}, {16'h0, exp});
    endtask : cmpB
    // expected fault word: summary set, power bit, code, seven flags
    function automatic logic [16:0] fw(input logic on, input logic [3:0] code, input logic [6:0] fl);
        return {2'b01, on, code, fl, 3'h0};
    endfunction : fw
    // one read; a missing answer ends the run rather than hanging
    task automatic rd(input logic [7:0] a);
        int n = 0;
        @(posedge clk_sys);
        rdReq <= 1'b1;
        rdAddr <= a;
        @(posedge clk_sys);
        rdReq <= 1'b0;
        #1;
        while (rdValid !== 1'b1 && n < 4) begin @(posedge clk_sys); #1; n++; end
        if (n == 4) begin failures++; end_of_test(); end
        word = rdData;
    endtask : rd
    // 0 limit, 1 over supply, 2 gnd leak, 3 bat leak, 4 overtemp, 5 on, 6 off, 7 error, 8 frame
    task automatic hold(input int f, input int n);
        @(posedge clk_sys);
        for (int v = 1; v >= 0; v--) begin
            case (f)
                0: rq[0].currentLimit <= v[0];
                1: rq[0].overSupply <= v[0];
                2: rq[0].overGndLeak <= v[0];
                3: rq[0].overBatLeak <= v[0];
                4: rq[0].overTemp <= v[0];
                5: rq[0].cmdOn <= v[0];
                6: rq[0].cmdOff <= v[0];
                7: rq[0].frameError <= v[0];
                default: rq[0].frameValid <= v[0];
            endcase
            if (v == 1) repeat (n) @(posedge clk_sys);
        end
    endtask : hold
    task automatic sreset(input logic warm);
        @(posedge clk_sys);
        if (warm) warmStateReset <= 1'b1; else softStateReset <= 1'b1;
        @(posedge clk_sys);
        warmStateReset <= 1'b0;
        softStateReset <= 1'b0;
    endtask : sreset
    task automatic t_reset();
        sreset(1'b1);
        rd(8'h50); cmpW(word[16:0], fw(1'b0, 4'h0, 7'h01));
        rd(8'h51); cmpW(word[16:0], fw(1'b0, 4'h4, 7'h01));
        rd(8'h52); cmpB(rdUnmapped, 1'b1);
    endtask : t_reset
    task automatic t_ground();
        hold(5, 1); @(posedge clk_sys); #1 cmpB(chanOn[0], 1'b1);
        hold(0, 1);
        rd(8'h50); cmpW(word[16:0], fw(1'b0, 4'h0, 7'h40));
        rd(8'h50); cmpW(word[16:0], fw(1'b0, 4'h0, 7'h40));
        hold(6, 1); @(posedge clk_sys);
        rq[0].payload <= 10'h2A5;
        rq[0].fifoEmpty <= 1'b0;
        hold(8, 1);
        rd(8'h50); cmpW(word[16:0], {7'h00, 10'h2A5}); cmpB(chanOn[0], 1'b0);
    endtask : t_ground
    task automatic t_frame();
        hold(7, 1); rd(8'h50); cmpW(word[16:0], {7'h00, 10'h2A5});
        @(posedge clk_sys); rq[0].fifoEmpty <= 1'b1;
        rd(8'h50); cmpW(word[16:0], {7'h00, 10'h2A5});
        hold(7, 1); rd(8'h50); cmpW(word[16:0], fw(1'b0, 4'h0, 7'h03));
        rd(8'h50); cmpW(word[16:0], fw(1'b0, 4'h0, 7'h01));
        hold(7, 1); hold(4, 1);
        rd(8'h50); cmpW(word[16:0], fw(1'b0, 4'h0, 7'h04));
        rd(8'h50); cmpW(word[16:0], fw(1'b0, 4'h0, 7'h04));
    endtask : t_frame
    // filtered faults: one edge short of the limit, then exactly at it, then read clear;
    // the up/down counters sit at the top one edge after the level drops, so the read waits
    task automatic t_qual();
        for (int f = 1; f <= 3; f++) begin
            sreset(1'b0); hold(f, (f == 1) ? STB : QUAL - 1);
            rd(8'h50); cmpW(word[16:0], fw(1'b0, 4'h0, 7'h01));
            sreset(1'b0); hold(f, (f == 1) ? STB + 1 : QUAL);
            @(posedge clk_sys);
            rd(8'h50); cmpW(word[16:0], fw(1'b0, 4'h0, 7'h40 >> f));
            rd(8'h50); cmpW(word[16:0], 17'h00000);
        end
    endtask : t_qual
    initial begin
        rq[0].fifoEmpty = 1'b1;
        rq[1].fifoEmpty = 1'b1;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset(); t_ground(); t_frame(); t_qual();
        end_of_test();
    end
endmodule : rsf_top_tb
bind rsf_top rsf_top_checker #(.STB_CYCLES(STB_CYCLES), .QUAL_LIMIT(QUAL_LIMIT)) rsf_top_checker_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .softStateReset(softStateReset), .warmStateReset(warmStateReset),
    .chanIn(chanIn), .rdReq(rdReq), .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid),
    .rdUnmapped(rdUnmapped), .chanOn(chanOn));

// ---- rsf_updown_qual.sv ----
// up/down counter that time-qualifies a current comparator level
`include "rsf_regs.svh"
module rsf_updown_qual #(
    parameter int unsigned LIMIT = `RSF_QUAL_LIMIT
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic clear,
    input  wire logic above,
    output logic      qualified
);
    localparam int unsigned CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] TOP = CW'(LIMIT);

    logic [CW-1:0] countReg;
    logic [CW-1:0] countNext;

    // counts up while above, down otherwise; short glitches cancel out instead of accumulating
    assign countNext = clear ? '0 :
                       (above && countReg != TOP) ? countReg + CW'(1) :
                       (!above && countReg != '0) ? countReg - CW'(1) : countReg;
    assign qualified = (countReg == TOP) && !clear;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) countReg <= '0;
        else        countReg <= countNext;
    end
endmodule : rsf_updown_qual
